// ### rots_pkg.sv
package rots_pkg;

	// Clock period and cycle timing, all referenced to the initiate pulse.
	localparam int CLK_NS     = 20;
	localparam int SEL_NS     = 130;
	localparam int HOLD_NS    = 60;
	localparam int PROT_NS    = 100;
	localparam int TE_SET_NS  = 165;
	localparam int XSTB_NS    = 185;
	localparam int TE_CLR_NS  = 265;
	localparam int OE_SET_NS  = 270;
	localparam int RSTB_NS    = 290;
	localparam int OE_CLR_NS  = 370;

	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] SEL_CYC    = CNT_W'((SEL_NS + CLK_NS / 2) / CLK_NS);
	localparam logic [CNT_W-1:0] HOLD_CYC   = CNT_W'((HOLD_NS + CLK_NS / 2) / CLK_NS);
	localparam logic [CNT_W-1:0] PROT_CYC   = CNT_W'((PROT_NS + CLK_NS / 2) / CLK_NS);
	localparam logic [CNT_W-1:0] TE_SET_CYC = CNT_W'((TE_SET_NS + CLK_NS / 2) / CLK_NS);
	localparam logic [CNT_W-1:0] XSTB_CYC   = CNT_W'((XSTB_NS + CLK_NS / 2) / CLK_NS);
	localparam logic [CNT_W-1:0] TE_CLR_CYC = CNT_W'((TE_CLR_NS + CLK_NS / 2) / CLK_NS);
	localparam logic [CNT_W-1:0] OE_SET_CYC = CNT_W'((OE_SET_NS + CLK_NS / 2) / CLK_NS);
	localparam logic [CNT_W-1:0] RSTB_CYC   = CNT_W'((RSTB_NS + CLK_NS / 2) / CLK_NS);
	localparam logic [CNT_W-1:0] OE_CLR_CYC = CNT_W'((OE_CLR_NS + CLK_NS / 2) / CLK_NS);

	// Data path layout: the outer half is bits 0-7 and 40-63.
	localparam int DATA_W = 64;
	localparam logic [63:0] OUTER_MASK = 64'hFFFF_FF00_0000_00FF;
	localparam logic [63:0] INNER_MASK = 64'h0000_00FF_FFFF_FF00;

	// Register map.
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFF  = 8'h00;
	localparam logic [7:0] STAT_OFF  = 8'h04;
	localparam logic [7:0] COUNT_OFF = 8'h08;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_CLEAR_BIT  = 1;

	typedef enum logic [1:0] {
		ROTS_IDLE  = 2'b00,
		ROTS_READ  = 2'b01,
		ROTS_WRITE = 2'b10,
		ROTS_XFER  = 2'b11
	} rots_cycle_type;

endpackage

// ### rots_sync.sv
`timescale 1ns/1ps
module rots_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : width_check
		$error("rots_sync needs a width of at least one bit.");
	end

	// The first stage feeds only the second stage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ### rots_switch.sv
`timescale 1ns/1ps
module rots_switch
	import rots_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              cabinet_clear_n,
	input  wire logic              mem_initiate,
	input  wire logic              mem_select,
	input  wire logic              transfer_initiate,
	input  wire logic              read_write_select,
	input  wire logic              route_select_bit0,
	input  wire logic              route_select_bit1,
	input  wire logic              outer_half_req,
	input  wire logic              inner_half_req,
	input  wire logic [DATA_W-1:0] memory_read_data,
	input  wire logic [DATA_W-1:0] element_data,
	output logic                   memory_initiate_out,
	output logic                   timing_chain_start,
	output logic [DATA_W-1:0]      buffer_data,
	output logic [DATA_W-1:0]      io_data,
	output logic                   buffer_gate_low_cards,
	output logic                   buffer_gate_high_cards,
	output logic                   io_gate_low_cards,
	output logic                   io_gate_high_cards,
	output logic                   buffer_strobe_lower_half,
	output logic                   buffer_strobe_upper_half,
	output logic                   io_data_strobe,
	output logic                   outer_write_enable,
	output logic                   inner_write_enable
);

	localparam int SYNC_W = 2 * DATA_W + 9;

	logic [SYNC_W-1:0] sync_s;
	logic              clear_n_s;
	logic              init_s;
	logic              msel_s;
	logic              xinit_s;
	logic              rw_s;
	logic              rb0_s;
	logic              rb1_s;
	logic              outer_s;
	logic              inner_s;
	logic [DATA_W-1:0] rdata_s;
	logic [DATA_W-1:0] edata_s;

	rots_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({cabinet_clear_n, mem_initiate, mem_select, transfer_initiate,
			read_write_select, route_select_bit0, route_select_bit1,
			outer_half_req, inner_half_req, memory_read_data, element_data}),
		.sync_out(sync_s)
	);

	assign {clear_n_s, init_s, msel_s, xinit_s, rw_s, rb0_s, rb1_s, outer_s, inner_s,
		rdata_s, edata_s} = sync_s;

	rots_cycle_type    cycle_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [31:0]       ctrl_q;
	logic [31:0]       done_count_q;
	logic [31:0]       prdata_q;
	logic              transfer_pending_q;
	logic              outer_half_latch_q;
	logic              inner_half_latch_q;
	logic              buffer_read_latch_q;
	logic              io_read_latch_q;
	logic              transfer_enable_q;
	logic              output_enable_q;
	logic              strobe_q;
	logic              write_enable_q;
	logic              memory_initiate_q;
	logic              timing_start_q;
	logic [DATA_W-1:0] holding_q;
	logic [DATA_W-1:0] buffer_data_q;
	logic [DATA_W-1:0] io_data_q;

	logic              clr;
	logic              busy;
	logic              start_mem;
	logic              start_xfer;
	logic              cycle_end;
	logic              read_req;
	logic              buf_sel;
	logic              io_sel;
	logic              hold_stb;
	logic              prot_pulse;
	logic              te_set;
	logic              te_clr;
	logic              oe_set;
	logic              oe_clr;
	logic              element_input_select;
	logic [DATA_W-1:0] half_sel;
	logic              reg_wr;
	logic              unmapped;

	// Cabinet clear and the software clear both wipe all cycle state; the control register and done count are kept.
	assign clr  = !clear_n_s || ctrl_q[CTRL_CLEAR_BIT];
	assign busy = cycle_q != ROTS_IDLE;

	// A transfer initiate wins over a memory initiate in the same cycle.
	// Initiates that arrive while a cycle runs are ignored, which relies on
	// the requester spacing them by at least a full cycle.
	assign start_xfer = ctrl_q[CTRL_ENABLE_BIT] && !busy && xinit_s;
	assign start_mem  = ctrl_q[CTRL_ENABLE_BIT] && !busy && !xinit_s && init_s && msel_s;
	assign cycle_end  = busy && cnt_q == OE_CLR_CYC;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_q <= ROTS_IDLE;
		end else if (clr) begin
			cycle_q <= ROTS_IDLE;
		end else begin
			case (cycle_q)
				ROTS_IDLE: begin
					if (start_xfer) begin
						cycle_q <= ROTS_XFER;
					end else if (start_mem) begin
						cycle_q <= rw_s ? ROTS_WRITE : ROTS_READ;
					end
				end
				ROTS_READ, ROTS_WRITE, ROTS_XFER: begin
					if (cycle_end) begin
						cycle_q <= ROTS_IDLE;
					end
				end
				default: cycle_q <= ROTS_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (clr || start_mem || start_xfer) begin
			cnt_q <= '0;
		end else if (busy && !cycle_end) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	assign te_set   = busy && cycle_q != ROTS_WRITE && cnt_q == TE_SET_CYC;
	assign te_clr   = busy && cnt_q == TE_CLR_CYC;
	assign oe_set   = cycle_q == ROTS_READ && cnt_q == OE_SET_CYC;
	assign oe_clr   = busy && cnt_q == OE_CLR_CYC;
	assign hold_stb = busy && cnt_q == HOLD_CYC;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transfer_pending_q <= 1'b0;
		end else if (clr || cycle_end) begin
			transfer_pending_q <= 1'b0;
		end else if (start_xfer) begin
			transfer_pending_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timing_start_q    <= 1'b0;
			memory_initiate_q <= 1'b0;
		end else if (clr) begin
			timing_start_q    <= 1'b0;
			memory_initiate_q <= 1'b0;
		end else begin
			timing_start_q    <= start_mem || start_xfer;
			memory_initiate_q <= start_mem && !rw_s && !transfer_pending_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			outer_half_latch_q <= 1'b0;
			inner_half_latch_q <= 1'b0;
		end else if (clr) begin
			outer_half_latch_q <= 1'b0;
			inner_half_latch_q <= 1'b0;
		end else if (start_mem || start_xfer) begin
			outer_half_latch_q <= outer_s;
			inner_half_latch_q <= inner_s;
		end
	end

	// The element inputs of the multiplexers open with the transfer flop.
	assign element_input_select = transfer_pending_q;
	assign half_sel = ({DATA_W{outer_half_latch_q && element_input_select}} & OUTER_MASK)
		| ({DATA_W{inner_half_latch_q && element_input_select}} & INNER_MASK);

	// Unselected bytes keep their old content rather than being zeroed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			holding_q <= '0;
		end else if (clr) begin
			holding_q <= '0;
		end else if (hold_stb) begin
			holding_q <= (holding_q & ~half_sel) | (~edata_s & half_sel);
		end
	end

	assign read_req = cycle_q == ROTS_READ && !transfer_pending_q;
	assign buf_sel  = read_req && !rb0_s && rb1_s;
	assign io_sel   = read_req && rb0_s && !rb1_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffer_read_latch_q <= 1'b0;
			io_read_latch_q     <= 1'b0;
		end else if (clr || cycle_end) begin
			buffer_read_latch_q <= 1'b0;
			io_read_latch_q     <= 1'b0;
		end else if (busy && cnt_q == SEL_CYC) begin
			buffer_read_latch_q <= buf_sel;
			io_read_latch_q     <= io_sel;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transfer_enable_q <= 1'b0;
		end else if (clr || te_clr) begin
			transfer_enable_q <= 1'b0;
		end else if (te_set) begin
			transfer_enable_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_enable_q <= 1'b0;
		end else if (clr || oe_clr) begin
			output_enable_q <= 1'b0;
		end else if (oe_set) begin
			output_enable_q <= 1'b1;
		end
	end

	// Set once per window in a read, once at 185 ns in a transfer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_q <= 1'b0;
		end else if (clr || te_clr || oe_clr) begin
			strobe_q <= 1'b0;
		end else if (busy && cycle_q != ROTS_WRITE && cnt_q == XSTB_CYC) begin
			strobe_q <= 1'b1;
		end else if (cycle_q == ROTS_READ && cnt_q == RSTB_CYC) begin
			strobe_q <= 1'b1;
		end
	end

	// Data are loaded on the set edge of their window, so they are valid
	// in the same cycle as the gate that carries them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffer_data_q <= '0;
		end else if (clr) begin
			buffer_data_q <= '0;
		end else if (te_set && transfer_pending_q) begin
			buffer_data_q <= ~holding_q;
		end else if (oe_set && buffer_read_latch_q) begin
			buffer_data_q <= ~rdata_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_data_q <= '0;
		end else if (clr) begin
			io_data_q <= '0;
		end else if (oe_set && io_read_latch_q) begin
			io_data_q <= ~rdata_s;
		end
	end

	// Write-enable path, kept only so that transfers can hold it off.
	assign prot_pulse = cycle_q == ROTS_WRITE && cnt_q == PROT_CYC
		&& !transfer_pending_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_enable_q <= 1'b0;
		end else if (clr || cycle_end || transfer_pending_q) begin
			write_enable_q <= 1'b0;
		end else if (prot_pulse) begin
			write_enable_q <= 1'b1;
		end
	end

	assign outer_write_enable = write_enable_q && outer_half_latch_q
		&& !transfer_pending_q;
	assign inner_write_enable = write_enable_q && inner_half_latch_q
		&& !transfer_pending_q;

	assign buffer_gate_low_cards  = (transfer_enable_q && transfer_pending_q)
		|| (output_enable_q && buffer_read_latch_q);
	assign buffer_gate_high_cards = buffer_gate_low_cards;
	assign io_gate_low_cards      = output_enable_q && io_read_latch_q;
	assign io_gate_high_cards     = io_gate_low_cards;

	// Strobes share the data gates, so a read's first strobe is dropped.
	assign buffer_strobe_lower_half = strobe_q && buffer_gate_low_cards;
	assign buffer_strobe_upper_half = strobe_q && buffer_gate_high_cards;
	assign io_data_strobe           = strobe_q && io_gate_low_cards;

	assign memory_initiate_out = memory_initiate_q;
	assign timing_chain_start  = timing_start_q;
	assign buffer_data         = buffer_data_q;
	assign io_data             = io_data_q;

	// APB slave with no wait states; read data is captured in the setup cycle.
	assign pready   = 1'b1;
	assign unmapped = paddr != CTRL_OFF && paddr != STAT_OFF && paddr != COUNT_OFF;
	assign pslverr  = psel && penable && unmapped;
	assign reg_wr   = psel && penable && pwrite && !unmapped;
	assign prdata   = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (reg_wr && paddr == CTRL_OFF) begin
			ctrl_q <= pwdata & 32'h0000_0003;
		end else begin
			ctrl_q[CTRL_CLEAR_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_count_q <= '0;
		end else if (reg_wr && paddr == COUNT_OFF) begin
			done_count_q <= '0;
		end else if (cycle_end) begin
			done_count_q <= done_count_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				CTRL_OFF:  prdata_q <= ctrl_q;
				STAT_OFF:  prdata_q <= {17'h0_0000, cnt_q, cycle_q, strobe_q, output_enable_q,
					transfer_enable_q, io_read_latch_q, buffer_read_latch_q,
					inner_half_latch_q, outer_half_latch_q, transfer_pending_q};
				COUNT_OFF: prdata_q <= done_count_q;
				default:   prdata_q <= '0;
			endcase
		end
	end

	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	te_window_len_a: assert property ($rose(transfer_enable_q)
		|-> transfer_enable_q[*5] ##1 !transfer_enable_q)
		else $error("Transfer enable window is not five cycles.");

	oe_window_len_a: assert property ($rose(output_enable_q)
		|-> output_enable_q[*5] ##1 !output_enable_q)
		else $error("Output enable window is not five cycles.");

	xfer_no_init_a: assert property ((transfer_pending_q || cycle_q == ROTS_XFER)
		|-> !memory_initiate_out)
		else $error("Memory initiate raised during a transfer.");

	xfer_no_we_a: assert property (transfer_pending_q
		|-> !outer_write_enable && !inner_write_enable)
		else $error("Write enable raised during a transfer.");

	read_te_quiet_a: assert property (cycle_q == ROTS_READ && transfer_enable_q
		|-> !buffer_strobe_lower_half && !io_data_strobe && !buffer_gate_low_cards)
		else $error("Read strobe leaked in the transfer enable period.");

	xfer_strobe_time_a: assert property ($rose(transfer_pending_q)
		|-> ##10 buffer_strobe_lower_half && buffer_strobe_upper_half)
		else $error("Transfer strobe not at the expected cycle.");

	xfer_gate_time_a: assert property ($rose(transfer_pending_q)
		|-> ##9 buffer_gate_low_cards && !$past(buffer_gate_low_cards))
		else $error("Transfer gating did not open at 165 ns.");

	// The cycle counter stands in for a long repetition of the closed gate.
	xfer_gate_early_a: assert property (transfer_pending_q && cnt_q <= TE_SET_CYC
		|-> !buffer_gate_low_cards)
		else $error("Transfer gating opened before 165 ns.");

	sel_latch_time_a: assert property ($rose(buffer_read_latch_q) || $rose(io_read_latch_q)
		|-> cnt_q == SEL_CYC + CNT_W'(1))
		else $error("Read select latch set at the wrong time.");

	one_dest_a: assert property (!(buffer_gate_low_cards && io_gate_low_cards))
		else $error("Both destinations gated at once.");

	read_data_inv_a: assert property ($rose(output_enable_q) && io_read_latch_q
		|-> io_data == ~$past(rdata_s))
		else $error("I/O read data not inverted copy of memory data.");

endmodule

// ### rots_partner.sv
`timescale 1ns/1ps
module rots_partner
	import rots_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              buffer_strobe_lower_half,
	input  wire logic              buffer_strobe_upper_half,
	input  wire logic              io_data_strobe,
	input  wire logic [DATA_W-1:0] buffer_data,
	input  wire logic [DATA_W-1:0] io_data,
	output logic      [DATA_W-1:0] buf_word_q,
	output logic      [DATA_W-1:0] io_word_q,
	output int                     stb_count_q
);
	logic lo_q;
	logic hi_q;
	logic io_q;

	// Each half is accepted on its own strobe edge, so a strobe that never rises loses its half.
	always_ff @(posedge pclk) begin
		lo_q <= buffer_strobe_lower_half;
		hi_q <= buffer_strobe_upper_half;
		io_q <= io_data_strobe;
		if (buffer_strobe_lower_half && !lo_q) begin
			buf_word_q[31:0] <= buffer_data[31:0];
		end
		if (buffer_strobe_upper_half && !hi_q) begin
			buf_word_q[63:32] <= buffer_data[63:32];
		end
		if (io_data_strobe && !io_q) begin
			io_word_q <= io_data;
		end
		if ((buffer_strobe_lower_half && !lo_q) || (io_data_strobe && !io_q)) begin
			stb_count_q <= stb_count_q + 1;
		end
	end
endmodule

// ### read_output_and_transfer_switch_tb.sv
`timescale 1ns/1ps
module read_output_and_transfer_switch_tb
	import rots_pkg::*;
;
	logic              pclk = 1'b0;
	logic              presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rv;
	logic              cabinet_clear_n, mem_initiate, mem_select, transfer_initiate;
	logic              read_write_select, route_select_bit0, route_select_bit1;
	logic              outer_half_req, inner_half_req, ev, seen;
	logic [63:0]       memory_read_data, element_data, buffer_data, io_data, p_buf, p_io;
	logic [63:0]       hold_m = 64'h0000_0000_0000_0000;
	logic              memory_initiate_out, timing_chain_start;
	logic              buffer_gate_low_cards, buffer_gate_high_cards;
	logic              io_gate_low_cards, io_gate_high_cards;
	logic              buffer_strobe_lower_half, buffer_strobe_upper_half, io_data_strobe;
	logic              outer_write_enable, inner_write_enable;
	logic [31:0]       rng_q = 32'h0000_0153;
	logic              clr_req = 1'b0;
	int                p_cnt, exp_cnt, errors, total_checks, cur_k;

	always #10 pclk = ~pclk;

	// The clear pin is driven on the rising edge like every other input.
	always @(posedge pclk) cabinet_clear_n <= !clr_req;

	rots_switch dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .cabinet_clear_n, .mem_initiate, .mem_select, .transfer_initiate,
		.read_write_select, .route_select_bit0, .route_select_bit1, .outer_half_req,
		.inner_half_req, .memory_read_data, .element_data, .memory_initiate_out,
		.timing_chain_start, .buffer_data, .io_data, .buffer_gate_low_cards,
		.buffer_gate_high_cards, .io_gate_low_cards, .io_gate_high_cards,
		.buffer_strobe_lower_half, .buffer_strobe_upper_half, .io_data_strobe,
		.outer_write_enable, .inner_write_enable);

	rots_partner far_u (.pclk, .buffer_strobe_lower_half, .buffer_strobe_upper_half,
		.io_data_strobe, .buffer_data, .io_data, .buf_word_q(p_buf), .io_word_q(p_io),
		.stb_count_q(p_cnt));

	function automatic logic [31:0] xs();
		rng_q ^= rng_q << 13;
		rng_q ^= rng_q >> 17;
		rng_q ^= rng_q << 5;
		return rng_q;
	endfunction

	task automatic chk_b(input logic got, input logic exp, input string m);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s (k=%0d)", $time, m, cur_k);
		end
	endtask

	task automatic chk_w(input logic [63:0] got, input logic [63:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s %h/%h", $time, m, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// The request is held until pready is sampled high; only then is it released.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One read or transfer; ab >= 0 pulls cabinet clear at that cycle index.
	task automatic run_cycle(input logic xf, input logic b0, input logic b1, input logic ou,
			input logic inr, input int ab);
		int n;
		logic g, s, to_b, to_i;
		logic [63:0] mem, elem, msk, exp_b;
		mem = {xs(), xs()};
		elem = {xs(), xs()};
		@(posedge pclk);
		route_select_bit0 <= b0;
		route_select_bit1 <= b1;
		read_write_select <= xf;
		outer_half_req <= ou;
		inner_half_req <= inr;
		memory_read_data <= mem;
		element_data <= elem;
		transfer_initiate <= xf;
		mem_initiate <= !xf;
		mem_select <= !xf;
		@(posedge pclk);
		transfer_initiate <= 1'b0;
		mem_initiate <= 1'b0;
		mem_select <= 1'b0;
		msk = (ou ? OUTER_MASK : 64'h0000_0000_0000_0000) | (inr ? INNER_MASK : 64'h0);
		if (xf) hold_m = (hold_m & ~msk) | (elem & msk);
		to_b = xf | (b1 & !b0);
		to_i = !xf & b0 & !b1;
		exp_b = xf ? hold_m : ~mem;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (timing_chain_start !== 1'b1 && n < 10);
		chk_b(timing_chain_start, 1'b1, "no start");
		for (int k = 0; k < 20; k++) begin
			cur_k = k;
			g = xf ? (k >= 9 && k <= 13) : (k >= 15 && k <= 19);
			s = xf ? (k >= 10 && k <= 13) : (k >= 16 && k <= 19);
			if (ab >= 0 && k == ab) clr_req = 1'b1;
			if (ab >= 0 && k >= ab) {g, s} = 2'b00;
			if (ab < 0 || k >= ab + 4) begin
				chk_b(memory_initiate_out, !xf && k == 0, "mem init");
				chk_b(buffer_gate_low_cards, g & to_b, "buf gate lo");
				chk_b(buffer_gate_high_cards, g & to_b, "buf gate hi");
				chk_b(io_gate_low_cards, g & to_i, "io gate lo");
				chk_b(io_gate_high_cards, g & to_i, "io gate hi");
				chk_b(buffer_strobe_lower_half, s & to_b, "buf stb lo");
				chk_b(buffer_strobe_upper_half, s & to_b, "buf stb hi");
				chk_b(io_data_strobe, s & to_i, "io stb");
				chk_b(outer_write_enable | inner_write_enable, 1'b0, "wr en");
				if (g & to_b) chk_w(buffer_data, exp_b, "buf data");
				if (g & to_i) chk_w(io_data, ~mem, "io data");
			end
			@(negedge pclk);
		end
		if (ab >= 0) begin
			// The clear takes four cycles through the pin synchroniser, so a
			// transfer strobe due before then still reaches the buffer.
			if (xf && ab + 4 > 10) exp_cnt++;
			clr_req = 1'b0;
			repeat (4) @(negedge pclk);
		end else begin
			if (to_b | to_i) exp_cnt++;
			if (to_b) chk_w(p_buf, exp_b, "far buf");
			if (to_i) chk_w(p_io, ~mem, "far io");
		end
	endtask

	initial begin
		{presetn, psel, penable, pwrite, mem_initiate, mem_select, transfer_initiate} = '0;
		{read_write_select, route_select_bit0, route_select_bit1} = '0;
		{outer_half_req, inner_half_req, paddr, pwdata} = '0;
		{memory_read_data, element_data} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, CTRL_OFF, 32'h0000_0000, rv, ev);
		chk_w({32'h0, rv}, {32'h0, CTRL_RESET}, "ctrl reset");
		apb(1'b0, 8'h0C, 32'h0000_0000, rv, ev);
		chk_b(ev, 1'b1, "unmapped err");
		run_cycle(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, -1);
		run_cycle(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, -1);
		run_cycle(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, -1);
		for (int i = 0; i < 4; i++) begin
			run_cycle(1'b0, i[0], i[1], 1'b0, 1'b0, -1);
		end
		apb(1'b0, COUNT_OFF, 32'h0000_0000, rv, ev);
		chk_w({32'h0, rv}, 64'h0000_0000_0000_0007, "count");
		apb(1'b1, CTRL_OFF, 32'h0000_0000, rv, ev);
		@(posedge pclk);
		transfer_initiate <= 1'b1;
		@(posedge pclk);
		transfer_initiate <= 1'b0;
		seen = 1'b0;
		repeat (25) begin
			@(negedge pclk);
			seen |= timing_chain_start;
		end
		chk_b(seen, 1'b0, "start while disabled");
		// Setting the clear bit along with enable must leave only enable behind.
		apb(1'b1, CTRL_OFF, 32'h0000_0003, rv, ev);
		apb(1'b0, CTRL_OFF, 32'h0000_0000, rv, ev);
		chk_w({32'h0, rv}, {32'h0, CTRL_RESET}, "ctrl clear bit");
		// A write cycle raises the write enables that every transfer must hold off.
		@(posedge pclk);
		{read_write_select, outer_half_req, inner_half_req} <= 3'b111;
		{mem_initiate, mem_select} <= 2'b11;
		@(posedge pclk);
		{mem_initiate, mem_select} <= 2'b00;
		repeat (12) @(negedge pclk);
		chk_b(outer_write_enable & inner_write_enable, 1'b1, "write en");
		repeat (20) @(negedge pclk);
		run_cycle(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 10);
		run_cycle(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, -1);
		chk_w(64'(p_cnt), 64'(exp_cnt), "strobe count");
		end_of_test();
	end

	// Whole run is a few hundred cycles; this margin only catches a hang.
	initial begin
		#(20 * 6000);
		errors++;
		end_of_test();
	end
endmodule
